/* logic/lma_pkg.sv */
package lma_pkg;
   // apb address width and register indexes; byte address is index times four
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_ADDR_HIGH = 8'h28;
   localparam logic [7:0] IDX_ADDR_LOW = 8'h29;
   localparam logic [7:0] IDX_OFF_HIGH = 8'h2A;
   localparam logic [7:0] IDX_OFF_LOW = 8'h2B;
   localparam logic [7:0] IDX_CTRL = 8'h2C;
   localparam logic [7:0] IDX_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h33;

   // field positions in the address and offset high bytes, plus the control launch bit and the status busy bit
   localparam int ID_BIT = 7;
   localparam int DIR_BIT = 6;
   localparam int OFF_BIT = 5;
   localparam int IND_BIT = 4;
   localparam int LEN_MSB = 3;
   localparam int LEN_LSB = 2;
   localparam int ENTRY_HI_MSB = 1;
   localparam int OFF_HI_MSB = 6;
   localparam int LAUNCH_BIT = 0;
   localparam int BUSY_BIT = 0;

   // interrupt sources
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_N = 2;

   // payload length codes and byte counts
   localparam logic [1:0] LEN_NONE = 2'h0;
   localparam logic [1:0] LEN_TWO = 2'h1;
   localparam logic [1:0] LEN_FOUR = 2'h2;
   localparam logic [1:0] LEN_EIGHT = 2'h3;
   localparam logic [3:0] NBYTES_NONE = 4'h0;
   localparam logic [3:0] NBYTES_TWO = 4'h2;
   localparam logic [3:0] NBYTES_FOUR = 4'h4;
   localparam logic [3:0] NBYTES_EIGHT = 4'h8;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic ID_VALUE = 1'b1;

   typedef enum logic [0:0] {LMA_IDLE = 1'b0, LMA_BUSY = 1'b1} lma_state_e;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : byte_addr
endpackage : lma_pkg

/* logic/lma_irq.sv */
`timescale 1ns/1ps
module lma_irq #(
   parameter int N = lma_pkg::IRQ_N
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] set,
   input wire logic en_we,
   input wire logic [N-1:0] en_wdata,
   input wire logic clr_we,
   input wire logic [N-1:0] clr_wdata,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic irq
);
   import lma_pkg::*;

   logic [N-1:0] next_status;
   logic [N-1:0] next_enable;
   logic next_irq;

   // sticky bits, a set in the clear cycle wins
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign next_status[i] = set[i] | (status[i] & ~(clr_we & clr_wdata[i]));
   end
   assign next_enable = en_we ? en_wdata : enable;
   assign next_irq = |(next_status & next_enable);

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         enable <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq <= next_irq;
      end
   end

   chk_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      set[0] |=> status[0]) else $error("status bit lost its set");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(status & enable)) else $error("irq does not follow status and enable");
endmodule : lma_irq

/* logic/lma_launch.sv */
`timescale 1ns/1ps
module lma_launch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic launch,
   input wire logic dir_in,
   input wire logic off_mode_in,
   input wire logic ind_in,
   input wire logic [1:0] len_in,
   input wire logic [9:0] entry_in,
   input wire logic [14:0] offset_in,
   input wire logic xfer_done,
   input wire logic xfer_error,
   input wire logic [15:0] xfer_err_code,
   output logic xfer_start,
   output logic xfer_dir,
   output logic xfer_offset_en,
   output logic xfer_indirect,
   output logic [1:0] xfer_len,
   output logic [3:0] xfer_nbytes,
   output logic [9:0] xfer_entry,
   output logic [14:0] xfer_offset,
   output logic busy,
   output logic last_error,
   output logic done_evt,
   output logic err_evt,
   output logic errcode_we,
   output logic [15:0] errcode_data
);
   import lma_pkg::*;

   lma_state_e state, next_state;
   logic next_start, next_dir, next_offset_en, next_indirect, next_last_error;
   logic next_done_evt, next_err_evt, next_errcode_we;
   logic [1:0] next_len;
   logic [3:0] next_nbytes;
   logic [9:0] next_entry;
   logic [14:0] next_offset;
   logic [15:0] next_errcode_data;

   // transfer sequencer, fields frozen at launch
   always_comb begin
      next_state = state;
      next_start = 1'b0;
      next_dir = xfer_dir;
      next_offset_en = xfer_offset_en;
      next_indirect = xfer_indirect;
      next_len = xfer_len;
      next_nbytes = xfer_nbytes;
      next_entry = xfer_entry;
      next_offset = xfer_offset;
      next_last_error = last_error;
      next_done_evt = 1'b0;
      next_err_evt = 1'b0;
      next_errcode_we = 1'b0;
      next_errcode_data = errcode_data;
      case (state)
         LMA_IDLE: begin
            if (launch) begin
               next_state = LMA_BUSY;
               next_start = 1'b1;
               next_dir = dir_in;
               next_offset_en = off_mode_in;
               next_indirect = ind_in;
               next_len = len_in;
               next_entry = entry_in;
               next_offset = off_mode_in ? offset_in : '0;
               case (len_in)
                  LEN_EIGHT: next_nbytes = NBYTES_EIGHT;
                  LEN_FOUR: next_nbytes = NBYTES_FOUR;
                  LEN_TWO: next_nbytes = NBYTES_TWO;
                  default: next_nbytes = NBYTES_NONE;
               endcase
            end
         end
         LMA_BUSY: begin
            if (xfer_done) begin
               next_state = LMA_IDLE;
               next_last_error = xfer_error;
               next_done_evt = 1'b1;
               next_err_evt = xfer_error;
               next_errcode_we = xfer_error;
               next_errcode_data = xfer_error ? xfer_err_code : errcode_data;
            end
         end
         default: next_state = LMA_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LMA_IDLE;
         xfer_start <= 1'b0;
         xfer_dir <= 1'b0;
         xfer_offset_en <= 1'b0;
         xfer_indirect <= 1'b0;
         xfer_len <= LEN_NONE;
         xfer_nbytes <= NBYTES_NONE;
         xfer_entry <= '0;
         xfer_offset <= '0;
         busy <= 1'b0;
         last_error <= 1'b0;
         done_evt <= 1'b0;
         err_evt <= 1'b0;
         errcode_we <= 1'b0;
         errcode_data <= '0;
      end else begin
         state <= next_state;
         xfer_start <= next_start;
         xfer_dir <= next_dir;
         xfer_offset_en <= next_offset_en;
         xfer_indirect <= next_indirect;
         xfer_len <= next_len;
         xfer_nbytes <= next_nbytes;
         xfer_entry <= next_entry;
         xfer_offset <= next_offset;
         busy <= (next_state == LMA_BUSY);
         last_error <= next_last_error;
         done_evt <= next_done_evt;
         err_evt <= next_err_evt;
         errcode_we <= next_errcode_we;
         errcode_data <= next_errcode_data;
      end
   end
endmodule : lma_launch

/* logic/lma_regs.sv */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module lma_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [lma_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic xfer_start,
   output logic xfer_dir,
   output logic xfer_offset_en,
   output logic xfer_indirect,
   output logic [1:0] xfer_len,
   output logic [3:0] xfer_nbytes,
   output logic [9:0] xfer_entry,
   output logic [14:0] xfer_offset,
   input wire logic xfer_done,
   input wire logic xfer_error,
   input wire logic [15:0] xfer_err_code,
   output logic errcode_we,
   output logic [15:0] errcode_data,
   output logic irq
);
   import lma_pkg::*;

   // software copies of the long message fields
   logic dir, off_mode, ind;
   logic [1:0] len;
   logic [9:0] entry;
   logic [14:0] offset;
   logic next_dir, next_off_mode, next_ind;
   logic [1:0] next_len;
   logic [9:0] next_entry;
   logic [14:0] next_offset;

   // bus state
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic setup, commit, wr, mapped;
   logic sel_addr_high, sel_addr_low, sel_off_high, sel_off_low, sel_ctrl;
   logic sel_status, sel_irq_status, sel_irq_enable, sel_irq_clear;

   // sequencer and interrupt links
   logic launch, busy, last_error, done_evt, err_evt;
   logic [IRQ_N-1:0] irq_set, irq_status, irq_enable;

   // address decode
   assign sel_addr_high = (paddr == byte_addr(IDX_ADDR_HIGH));
   assign sel_addr_low = (paddr == byte_addr(IDX_ADDR_LOW));
   assign sel_off_high = (paddr == byte_addr(IDX_OFF_HIGH));
   assign sel_off_low = (paddr == byte_addr(IDX_OFF_LOW));
   assign sel_ctrl = (paddr == byte_addr(IDX_CTRL));
   assign sel_status = (paddr == byte_addr(IDX_STATUS));
   assign sel_irq_status = (paddr == byte_addr(IDX_IRQ_STATUS));
   assign sel_irq_enable = (paddr == byte_addr(IDX_IRQ_ENABLE));
   assign sel_irq_clear = (paddr == byte_addr(IDX_IRQ_CLEAR));
   assign mapped = sel_addr_high | sel_addr_low | sel_off_high | sel_off_low | sel_ctrl
                 | sel_status | sel_irq_status | sel_irq_enable | sel_irq_clear;

   // apb phases; a write lands only on the completing access edge
   assign setup = psel & ~penable;
   assign commit = psel & penable & pready;
   assign wr = commit & pwrite & mapped;

   // launch strobe from the control register
   assign launch = wr & sel_ctrl & pwdata[LAUNCH_BIT];

   // read mux and ready, prepared in the setup cycle
   always_comb begin
      next_prdata = '0;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (setup) begin
         next_pready = 1'b1;
         next_pslverr = ~mapped;
         if (!pwrite) begin
            if (sel_addr_high) begin
               next_prdata[ID_BIT] = ID_VALUE;
               next_prdata[OFF_BIT] = last_error;
            end else if (sel_off_high) begin
               next_prdata[ID_BIT] = ID_VALUE;
            end else if (sel_status) begin
               next_prdata[BUSY_BIT] = busy;
            end else if (sel_irq_status) begin
               next_prdata[IRQ_N-1:0] = irq_status;
            end else if (sel_irq_enable) begin
               next_prdata[IRQ_N-1:0] = irq_enable;
            end
         end
      end
   end

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // field writes; reads never see these values
   always_comb begin
      next_dir = dir;
      next_off_mode = off_mode;
      next_ind = ind;
      next_len = len;
      next_entry = entry;
      next_offset = offset;
      if (wr && sel_addr_high) begin
         next_dir = pwdata[DIR_BIT];
         next_off_mode = pwdata[OFF_BIT];
         next_ind = pwdata[IND_BIT];
         next_len = pwdata[LEN_MSB:LEN_LSB];
         next_entry[9:8] = pwdata[ENTRY_HI_MSB:0];
      end
      if (wr && sel_addr_low) begin
         next_entry[7:0] = pwdata[7:0];
      end
      if (wr && sel_off_high) begin
         next_offset[14:8] = pwdata[OFF_HI_MSB:0];
      end
      if (wr && sel_off_low) begin
         next_offset[7:0] = pwdata[7:0];
      end
   end

   // field registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir <= 1'b0;
         off_mode <= 1'b0;
         ind <= 1'b0;
         len <= LEN_NONE;
         entry <= '0;
         offset <= '0;
      end else begin
         dir <= next_dir;
         off_mode <= next_off_mode;
         ind <= next_ind;
         len <= next_len;
         entry <= next_entry;
         offset <= next_offset;
      end
   end

   // transfer sequencer, snapshots fields at launch
   lma_launch u_launch (
      .pclk(pclk),
      .presetn(presetn),
      .launch(launch),
      .dir_in(dir),
      .off_mode_in(off_mode),
      .ind_in(ind),
      .len_in(len),
      .entry_in(entry),
      .offset_in(offset),
      .xfer_done(xfer_done),
      .xfer_error(xfer_error),
      .xfer_err_code(xfer_err_code),
      .xfer_start(xfer_start),
      .xfer_dir(xfer_dir),
      .xfer_offset_en(xfer_offset_en),
      .xfer_indirect(xfer_indirect),
      .xfer_len(xfer_len),
      .xfer_nbytes(xfer_nbytes),
      .xfer_entry(xfer_entry),
      .xfer_offset(xfer_offset),
      .busy(busy),
      .last_error(last_error),
      .done_evt(done_evt),
      .err_evt(err_evt),
      .errcode_we(errcode_we),
      .errcode_data(errcode_data)
   );

   // completion and error events into the interrupt unit
   assign irq_set[IRQ_DONE] = done_evt;
   assign irq_set[IRQ_ERR] = err_evt;

   lma_irq #(.N(IRQ_N)) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .set(irq_set),
      .en_we(wr & sel_irq_enable),
      .en_wdata(pwdata[IRQ_N-1:0]),
      .clr_we(wr & sel_irq_clear),
      .clr_wdata(pwdata[IRQ_N-1:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

   // checks on reads
   chk_id_bit_high: assert property (@(posedge pclk) disable iff (!presetn)
      commit && !pwrite && (sel_addr_high || sel_off_high) |-> prdata[ID_BIT])
      else $error("identification bit did not read as one");
   chk_offset_wo: assert property (@(posedge pclk) disable iff (!presetn)
      commit && !pwrite && (sel_off_low || sel_addr_low) |-> prdata == '0)
      else $error("write-only register returned data");
   chk_error_read: assert property (@(posedge pclk) disable iff (!presetn)
      commit && !pwrite && sel_addr_high |-> prdata[OFF_BIT] == $past(last_error))
      else $error("offset mode flag does not report last error");

   // checks on capture and transfer
   chk_launch_capture: assert property (@(posedge pclk) disable iff (!presetn)
      launch && !busy |=> xfer_start && xfer_dir == $past(dir)
         && xfer_indirect == $past(ind) && xfer_entry == $past(entry))
      else $error("launch did not capture the fields");
   chk_offset_gate: assert property (@(posedge pclk) disable iff (!presetn)
      xfer_start |-> (xfer_offset_en ? 1'b1 : xfer_offset == '0)
         && (xfer_offset_en == $past(off_mode)))
      else $error("offset sent without offset mode");
   chk_len_bytes: assert property (@(posedge pclk) disable iff (!presetn)
      xfer_start |-> xfer_nbytes == ((xfer_len == LEN_EIGHT) ? NBYTES_EIGHT
         : (xfer_len == LEN_FOUR) ? NBYTES_FOUR
         : (xfer_len == LEN_TWO) ? NBYTES_TWO : NBYTES_NONE))
      else $error("byte count does not match length code");
   chk_entry_split: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_addr_high |=> entry[9:8] == $past(pwdata[ENTRY_HI_MSB:0])
         && entry[7:0] == $past(entry[7:0]))
      else $error("entry high bits not taken from high byte");
   chk_hold_busy: assert property (@(posedge pclk) disable iff (!presetn)
      busy && !xfer_done |=> $stable(xfer_entry) && $stable(xfer_offset)
         && $stable(xfer_len) && $stable(xfer_dir))
      else $error("transfer fields changed while busy");
   chk_errcode_out: assert property (@(posedge pclk) disable iff (!presetn)
      busy && xfer_done && xfer_error |=> errcode_we
         && errcode_data == $past(xfer_err_code) && last_error)
      else $error("error code not delivered to payload bytes");
   chk_ind_capture: assert property (@(posedge pclk) disable iff (!presetn)
      launch && !busy |=> xfer_indirect == $past(ind))
      else $error("indirect select not captured");
   chk_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("apb answer not given in the access cycle");
endmodule : lma_regs

/* tb/lma_link_model.sv */
`timescale 1ns/1ps
// far end of the long message link: answers each launch after a set delay
module lma_link_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic xfer_start,
   input wire logic [7:0] delay,
   input wire logic err_en,
   input wire logic [15:0] err_code,
   output logic xfer_done,
   output logic xfer_error,
   output logic [15:0] xfer_err_code
);
   int cnt;

   // outputs known from time zero
   initial begin
      cnt = 0;
      xfer_done = 1'b0;
      xfer_error = 1'b0;
      xfer_err_code = 16'hA5A5;
   end

   // countdown from launch, one-cycle done pulse with verdict and code
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt = 0;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= 1'b0;
         // error and code carry junk outside the done pulse
         xfer_error <= ~xfer_error;
         xfer_err_code <= ~xfer_err_code;
         if (xfer_start) begin
            cnt = int'(delay);
         end else if (cnt > 0) begin
            cnt = cnt - 1;
            if (cnt == 0) begin
               xfer_done <= 1'b1;
               xfer_error <= err_en;
               xfer_err_code <= err_code;
            end
         end
      end
   end
endmodule : lma_link_model

/* tb/long_msg_address_regs_test.sv */
`timescale 1ns/1ps
module long_msg_address_regs_test;
   import lma_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, xfer_start, xfer_dir, xfer_offset_en, xfer_indirect;
   logic [1:0] xfer_len;
   logic [3:0] xfer_nbytes;
   logic [9:0] xfer_entry;
   logic [14:0] xfer_offset;
   logic xfer_done, xfer_error, errcode_we, irq;
   logic [15:0] xfer_err_code, errcode_data;
   logic [7:0] delay = 8'h01;
   logic err_en = 1'b0;
   logic [15:0] err_code = 16'h0000;
   int mismatches = 0;
   int checks_done = 0;
   int n_start = 0, n_done = 0, n_ewe = 0;
   logic [31:0] seed = 32'h7399;
   logic [31:0] rd;
   logic slv;

   always #2.5 pclk = ~pclk;

   lma_regs uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .xfer_start, .xfer_dir, .xfer_offset_en, .xfer_indirect,
      .xfer_len, .xfer_nbytes, .xfer_entry, .xfer_offset, .xfer_done, .xfer_error,
      .xfer_err_code, .errcode_we, .errcode_data, .irq);

   lma_link_model link (.pclk, .presetn, .xfer_start, .delay, .err_en, .err_code,
      .xfer_done, .xfer_error, .xfer_err_code);

   // pulse counters on the transfer side
   always @(posedge pclk) begin
      if (xfer_start === 1'b1) n_start++;
      if (xfer_done === 1'b1) n_done++;
      if (errcode_we === 1'b1) n_ewe++;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // byte count expected for a length code
   function automatic logic [3:0] len_bytes(input logic [1:0] c);
      return (c == 2'h0) ? 4'h0 : (4'h1 << c);
   endfunction : len_bytes

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   // one apb transfer: setup, access, wait for pready, then release
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      paddr <= {2'h0, idx, 2'h0};
      pwrite <= wr;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n == 50) check(32'h0, 32'h1, "apb no answer");
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(rd, exp, $sformatf("read index %0h", idx));
   endtask : rdchk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // watchdog well beyond the expected run of a few microseconds
   initial begin
      #50us;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      logic [31:0] r;
      logic dir, off, ind, err;
      logic [1:0] len, en;
      logic [9:0] ent;
      logic [14:0] ofs;
      int n, n_err;
      n_err = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, identification bits, write-only offset, unmapped place
      rdchk(IDX_ADDR_HIGH, 32'h80);
      rdchk(IDX_OFF_HIGH, 32'h80);
      apb(1'b1, IDX_OFF_LOW, 32'h5A);
      rdchk(IDX_OFF_LOW, 32'h0);
      apb(1'b1, IDX_OFF_HIGH, 32'h7F);
      rdchk(IDX_OFF_HIGH, 32'h80);
      apb(1'b0, 8'h2D, 32'h0);
      check(slv, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      $display("test reset_map done");
      // random transfers, every length code, corner fields first
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         {ofs, ent, err, en} = r[27:0];
         {dir, off, ind} = r[30:28];
         len = i[1:0];
         if (i == 0) {ent, ofs, off} = {10'h3FF, 15'h7FFF, 1'b1};
         if (i == 1) {ent, ofs} = {10'h000, 15'h0000};
         err_en <= err;
         err_code <= r[31:16];
         delay <= (i == 0) ? 8'h01 : {4'h3, r[31:28]};
         apb(1'b1, IDX_IRQ_ENABLE, {30'h0, en});
         apb(1'b1, IDX_ADDR_HIGH, {24'h0, 1'b0, dir, off, ind, len, ent[9:8]});
         apb(1'b1, IDX_ADDR_LOW, {24'h0, ent[7:0]});
         apb(1'b1, IDX_OFF_HIGH, {24'h0, 1'b0, ofs[14:8]});
         apb(1'b1, IDX_OFF_LOW, {24'h0, ofs[7:0]});
         apb(1'b1, IDX_CTRL, 32'h1);
         // while busy: new fields and a second launch must change nothing
         if (i > 0) begin
            rdchk(IDX_STATUS, 32'h1);
            apb(1'b1, IDX_ADDR_HIGH, {24'h0, 1'b0, ~dir, ~off, ~ind, ~len, ~ent[9:8]});
            apb(1'b1, IDX_ADDR_LOW, {24'h0, ~ent[7:0]});
            apb(1'b1, IDX_OFF_LOW, {24'h0, ~ofs[7:0]});
            apb(1'b1, IDX_CTRL, 32'h1);
         end
         n = 0;
         while (n_done <= i && n < 200) begin
            n++;
            @(posedge pclk);
         end
         if (n == 200) check(32'h0, 32'h1, "no completion");
         repeat (3) @(posedge pclk);
         n_err += int'(err);
         check(n_start, i + 1, "launch count");
         check(xfer_dir, dir, "direction");
         check(xfer_offset_en, off, "offset mode");
         check(xfer_offset, off ? ofs : 15'h0, "offset");
         check(xfer_indirect, ind, "indirect");
         check(xfer_len, len, "length code");
         check(xfer_nbytes, len_bytes(len), "byte count");
         check(xfer_entry, ent, "entry");
         check(n_ewe, n_err, "error code strobes");
         if (err) check(errcode_data, err_code, "error code");
         rdchk(IDX_ADDR_HIGH, {24'h0, 1'b1, 1'b0, err, 5'h0});
         // sticky events, mask and write-one clear
         check(irq, |({err, 1'b1} & en), "irq level");
         rdchk(IDX_IRQ_STATUS, {30'h0, err, 1'b1});
         rdchk(IDX_IRQ_ENABLE, {30'h0, en});
         apb(1'b1, IDX_IRQ_CLEAR, 32'h3);
         rdchk(IDX_IRQ_STATUS, 32'h0);
         check(irq, 1'b0, "irq after clear");
         rdchk(IDX_STATUS, 32'h0);
         $display("test transfer %0d done", i);
      end
      end_of_test();
   end
endmodule : long_msg_address_regs_test
